// ==== design/csbu_compare_skip_branch_unit.v ====
// Function
// - Compare with carry sets flags, one cycle
// - Compare immediate sets flags, one cycle
// - Skip when register bit clear
// - Skip when register bit set
// - Skip when I/O bit clear
// - Skip when I/O bit set
// - Branch relative when status bit set
// - Branch relative when status bit clear
// - Branch on zero set or clear
// - Branch on carry set or clear
// - Unsigned same-or-higher and lower branches
// - Branch on negative set or clear
`timescale 1ns/1ps
`include "csbu_regs.vh"

module csbu_compare_skip_branch_unit #(
    parameter PC_WIDTH = 16
) (
    input  wire                ref_clk,
    input  wire                rst,
    input  wire                ce,
    input  wire                issueValid,
    output wire                issueReady,
    input  wire [3:0]          opSel,
    input  wire [7:0]          operandA,
    input  wire [7:0]          operandB,
    input  wire [2:0]          bitSel,
    input  wire [6:0]          branchOffset,
    input  wire [PC_WIDTH-1:0] pcIn,
    input  wire                nextTwoWord,
    input  wire [7:0]          statusIn,
    input  wire [5:0]          ioAddrIn,
    output wire [5:0]          ioAddr,
    output wire                ioRead,
    input  wire [7:0]          ioData,
    output reg  [7:0]          flagsOut,
    output reg                 flagsWe,
    output reg  [PC_WIDTH-1:0] pcOut,
    output reg                 pcLoad,
    output reg                 done
);

    reg  [1:0]          cntQ;
    reg  [1:0]          cntD;
    reg  [7:0]          flagsD;
    reg                 flagsWeD;
    reg  [PC_WIDTH-1:0] pcD;
    reg                 pcLoadD;
    reg                 doneD;

    wire                accept;
    wire                busy;
    wire [7:0]          subB;
    wire                carryIn;
    wire [8:0]          diff;
    wire [7:0]          res;
    wire [7:0]          borrow;
    wire                ovf;
    wire                zeroRes;
    wire                chainZero;
    wire                regBit;
    wire                ioBit;
    wire                statBit;
    wire                isSkip;
    wire                isCompare;
    reg                 cond;
    wire [PC_WIDTH-1:0] offsetExt;
    wire [PC_WIDTH-1:0] branchTarget;
    wire [PC_WIDTH-1:0] skipTarget;
    wire [PC_WIDTH-1:0] offsetPlusOne;
    wire [1:0]          skipStep;
    wire                isIoSkip;
    reg                 condSkip;
    reg                 condBranch;

    wire                flagC;
    wire                flagH;
    wire                flagV;
    wire                flagN;
    wire                flagZ;
    reg  [7:0]          cmpFlags;

    wire                takeCompare;
    wire                takeFall;
    wire                takeSkip;
    wire                takeBranch;
    wire                lastWait;
    wire [1:0]          skipWait;

    // Every code of the 4-bit select is in use
    localparam          OP_COUNT = 16;
    wire [OP_COUNT-1:0] opHot;

    // Refusal while busy keeps the multi-cycle outcomes from overlapping
    assign busy       = (cntQ != `CSBU_RST_CNT);
    assign issueReady = ~busy;
    assign accept     = ce & issueValid & ~busy;

    // The I/O read is asked for in the issue cycle; the data must return in that cycle
    assign ioAddr = ioAddrIn;
    assign isIoSkip = opHot[`CSBU_OP_SKIP_IO_CLR] | opHot[`CSBU_OP_SKIP_IO_SET];
    assign ioRead   = issueValid & ~busy & isIoSkip;

    // One-hot decode of the operation select, one line per code
    genvar gOp;
    generate
        for (gOp = 0; gOp < OP_COUNT; gOp = gOp + 1) begin : g_opDecode
            localparam [3:0] OP_CODE = gOp;
            assign opHot[gOp] = (opSel == OP_CODE);
        end
    endgenerate

    assign isCompare = opHot[`CSBU_OP_CMP_CARRY] | opHot[`CSBU_OP_CMP_IMM];
    assign isSkip    = opHot[`CSBU_OP_SKIP_REG_CLR] | opHot[`CSBU_OP_SKIP_REG_SET] |
                       opHot[`CSBU_OP_SKIP_IO_CLR] | opHot[`CSBU_OP_SKIP_IO_SET];

    // Subtraction for both compares; the difference is never stored
    assign subB    = operandB;
    assign carryIn = (opSel == `CSBU_OP_CMP_CARRY) ? statusIn[`CSBU_FLAG_C] : 1'b0;
    assign diff    = {1'b0, operandA} - {1'b0, subB} - {8'h00, carryIn};
    assign res     = diff[7:0];
    genvar gBit;
    generate
        for (gBit = 0; gBit < 8; gBit = gBit + 1) begin : g_borrow
            // Borrow out of each bit position of the difference
            assign borrow[gBit] = (~operandA[gBit] & subB[gBit]) | (subB[gBit] & res[gBit]) |
                                  (res[gBit] & ~operandA[gBit]);
        end
    endgenerate
    assign ovf     = (operandA[7] & ~subB[7] & ~res[7]) | (~operandA[7] & subB[7] & res[7]);
    assign zeroRes = (res == 8'h00);
    // Carry-chained compare keeps zero only if it was already set, for multi-byte compares
    assign chainZero = (opSel == `CSBU_OP_CMP_CARRY) ? (zeroRes & statusIn[`CSBU_FLAG_Z]) : zeroRes;

    // Flag values a compare would write
    assign flagC = borrow[7];
    assign flagH = borrow[3];
    assign flagV = ovf;
    assign flagN = res[7];
    assign flagZ = chainZero;

    assign regBit  = operandA[bitSel];
    assign ioBit   = ioData[bitSel];
    assign statBit = statusIn[bitSel];

    assign offsetExt    = {{(PC_WIDTH-7){branchOffset[6]}}, branchOffset};
    assign offsetPlusOne = offsetExt + {{(PC_WIDTH-1){1'b0}}, 1'b1};
    assign branchTarget  = pcIn + offsetPlusOne;
    assign skipStep      = nextTwoWord ? `CSBU_SKIP_STEP_TWO : `CSBU_SKIP_STEP_ONE;
    assign skipTarget    = pcIn + {{(PC_WIDTH-2){1'b0}}, skipStep};

    // Skip tests look at a data bit, branch tests at a status flag
    always @* begin
        condSkip = 1'b0;
        case (opSel)
            `CSBU_OP_SKIP_REG_CLR:   condSkip = ~regBit;
            `CSBU_OP_SKIP_REG_SET:   condSkip = regBit;
            `CSBU_OP_SKIP_IO_CLR:    condSkip = ~ioBit;
            `CSBU_OP_SKIP_IO_SET:    condSkip = ioBit;
            default:                 condSkip = 1'b0;
        endcase
    end

    always @* begin
        condBranch = 1'b0;
        case (opSel)
            `CSBU_OP_BR_STAT_SET:    condBranch = statBit;
            `CSBU_OP_BR_STAT_CLR:    condBranch = ~statBit;
            `CSBU_OP_BR_EQUAL:       condBranch = statusIn[`CSBU_FLAG_Z];
            `CSBU_OP_BR_NOT_EQUAL:   condBranch = ~statusIn[`CSBU_FLAG_Z];
            `CSBU_OP_BR_CARRY_SET:   condBranch = statusIn[`CSBU_FLAG_C];
            `CSBU_OP_BR_CARRY_CLR:   condBranch = ~statusIn[`CSBU_FLAG_C];
            `CSBU_OP_BR_SAME_HIGHER: condBranch = ~statusIn[`CSBU_FLAG_C];
            `CSBU_OP_BR_LOWER:       condBranch = statusIn[`CSBU_FLAG_C];
            `CSBU_OP_BR_MINUS:       condBranch = statusIn[`CSBU_FLAG_N];
            `CSBU_OP_BR_PLUS:        condBranch = ~statusIn[`CSBU_FLAG_N];
            default:                 condBranch = 1'b0;
        endcase
    end

    // Compares fall to the branch side, whose default keeps them untaken
    always @* begin
        cond = isSkip ? condSkip : condBranch;
    end

    // Outcome of an accepted issue; exactly one of these is high per issue
    assign takeCompare = accept & isCompare;
    assign takeFall    = accept & ~isCompare & ~cond;
    assign takeSkip    = accept & ~isCompare & cond & isSkip;
    assign takeBranch  = accept & ~isCompare & cond & ~isSkip;
    assign lastWait    = busy & (cntQ == `CSBU_CYC_SINGLE);
    // Wait cycles after the PC load: the full count minus the load cycle
    assign skipWait    = (nextTwoWord ? `CSBU_CYC_SKIP_TWO : `CSBU_CYC_SKIP_ONE) - 2'h1;

    // Sign, transfer and interrupt bits pass through unchanged
    always @* begin
        cmpFlags               = statusIn;
        cmpFlags[`CSBU_FLAG_C] = flagC;
        cmpFlags[`CSBU_FLAG_H] = flagH;
        cmpFlags[`CSBU_FLAG_V] = flagV;
        cmpFlags[`CSBU_FLAG_N] = flagN;
        cmpFlags[`CSBU_FLAG_Z] = flagZ;
    end

    // Busy countdown; a new count is loaded only from idle
    always @* begin
        cntD = cntQ;
        if (busy) begin
            cntD = cntQ - 2'h1;
        end else if (takeSkip) begin
            cntD = skipWait;
        end else if (takeBranch) begin
            cntD = `CSBU_CYC_TAKEN - 2'h1;
        end
    end

    // Flags are written only by a compare
    always @* begin
        flagsD   = flagsOut;
        flagsWeD = 1'b0;
        if (takeCompare) begin
            flagsD   = cmpFlags;
            flagsWeD = 1'b1;
        end
    end

    // Fall-through leaves the PC to the fetch logic
    always @* begin
        pcD     = pcOut;
        pcLoadD = 1'b0;
        if (takeSkip) begin
            pcD     = skipTarget;
            pcLoadD = 1'b1;
        end else if (takeBranch) begin
            pcD     = branchTarget;
            pcLoadD = 1'b1;
        end
    end

    // Single-cycle outcomes finish at once, multi-cycle ones on the last wait
    always @* begin
        doneD = 1'b0;
        if (lastWait | takeFall) begin
            doneD = 1'b1;
        end else if (takeCompare) begin
            doneD = 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            cntQ <= `CSBU_RST_CNT;
        end else if (ce) begin
            cntQ <= cntD;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            flagsOut <= `CSBU_RST_FLAGS;
        end else if (ce) begin
            flagsOut <= flagsD;
        end
    end

    // Pulses freeze with ce too, so a stalled consumer still sees them
    always @(posedge ref_clk) begin
        if (rst) begin
            flagsWe <= 1'b0;
        end else if (ce) begin
            flagsWe <= flagsWeD;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            pcOut <= {PC_WIDTH{1'b0}};
        end else if (ce) begin
            pcOut <= pcD;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            pcLoad <= 1'b0;
        end else if (ce) begin
            pcLoad <= pcLoadD;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            done <= 1'b0;
        end else if (ce) begin
            done <= doneD;
        end
    end

endmodule

// ==== design/csbu_regs.vh ====
`ifndef CSBU_REGS_VH
`define CSBU_REGS_VH

// Operation select codes presented with an issue
`define CSBU_OP_CMP_CARRY      4'h0
`define CSBU_OP_CMP_IMM        4'h1
`define CSBU_OP_SKIP_REG_CLR   4'h2
`define CSBU_OP_SKIP_REG_SET   4'h3
`define CSBU_OP_SKIP_IO_CLR    4'h4
`define CSBU_OP_SKIP_IO_SET    4'h5
`define CSBU_OP_BR_STAT_SET    4'h6
`define CSBU_OP_BR_STAT_CLR    4'h7
`define CSBU_OP_BR_EQUAL       4'h8
`define CSBU_OP_BR_NOT_EQUAL   4'h9
`define CSBU_OP_BR_CARRY_SET   4'hA
`define CSBU_OP_BR_CARRY_CLR   4'hB
`define CSBU_OP_BR_SAME_HIGHER 4'hC
`define CSBU_OP_BR_LOWER       4'hD
`define CSBU_OP_BR_MINUS       4'hE
`define CSBU_OP_BR_PLUS        4'hF

// Status flag bit positions
`define CSBU_FLAG_C 0
`define CSBU_FLAG_Z 1
`define CSBU_FLAG_N 2
`define CSBU_FLAG_V 3
`define CSBU_FLAG_H 5

// Cycle counts per instruction outcome
`define CSBU_CYC_SINGLE   2'h1
`define CSBU_CYC_TAKEN    2'h2
`define CSBU_CYC_SKIP_ONE 2'h2
`define CSBU_CYC_SKIP_TWO 2'h3

// Program counter step past one- or two-word instruction
`define CSBU_SKIP_STEP_ONE 2'h2
`define CSBU_SKIP_STEP_TWO 2'h3

// Reset values
`define CSBU_RST_FLAGS 8'h00
`define CSBU_RST_CNT   2'h0

`endif

// ==== dv/csbu_compare_skip_branch_unit_monitor.sv ====
`timescale 1ns/1ps
`include "csbu_regs.vh"
module csbu_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       issueValid,
    input wire logic       issueReady,
    input wire logic [3:0] opSel,
    input wire logic [7:0] operandA,
    input wire logic [2:0] bitSel,
    input wire logic       nextTwoWord,
    input wire logic [7:0] statusIn,
    input wire logic [7:0] ioData,
    input wire logic       ioRead,
    input wire logic       flagsWe,
    input wire logic       pcLoad,
    input wire logic       done
);
    wire take = issueValid && issueReady;
    default clocking cb @(posedge ref_clk); endclocking
    // A frozen clock enable stretches every count, so those cycles are not judged
    default disable iff (rst || !ce);
    sequence s_two; pcLoad && !done ##1 done; endsequence
    property p_cmp; take && opSel[3:1] == 3'h0 |=> flagsWe && done; endproperty
    property p_noflag; take && opSel[3:1] != 3'h0 |=> !flagsWe; endproperty
    property p_eq; take && opSel == `CSBU_OP_BR_EQUAL && statusIn[1] |=> s_two; endproperty
    property p_ne; take && opSel == `CSBU_OP_BR_NOT_EQUAL && statusIn[1] |=> done && !pcLoad; endproperty
    property p_cs; take && opSel == `CSBU_OP_BR_CARRY_SET && !statusIn[0] |=> done && !pcLoad; endproperty
    property p_skip2; take && opSel == `CSBU_OP_SKIP_REG_SET && operandA[bitSel] && nextTwoWord
        |=> pcLoad ##1 !done ##1 done; endproperty
    property p_ioskip; take && opSel == `CSBU_OP_SKIP_IO_CLR && !ioData[bitSel] && !nextTwoWord |=> s_two; endproperty
    property p_ioread; take && opSel == `CSBU_OP_SKIP_IO_SET |-> ioRead; endproperty
    property p_busy; pcLoad |-> !issueReady; endproperty
    a_cmp: assert property (p_cmp) else $error("compare not done in one cycle");
    a_noflag: assert property (p_noflag) else $error("flags written by skip or branch");
    a_eq: assert property (p_eq) else $error("taken equal branch timing wrong");
    a_ne: assert property (p_ne) else $error("not-equal branch wrongly taken");
    a_cs: assert property (p_cs) else $error("carry branch wrongly taken");
    a_skip2: assert property (p_skip2) else $error("two-word skip timing wrong");
    a_ioskip: assert property (p_ioskip) else $error("io skip timing wrong");
    a_ioread: assert property (p_ioread) else $error("io register not read");
    a_busy: assert property (p_busy) else $error("issue accepted while busy");
endmodule
bind csbu_compare_skip_branch_unit csbu_monitor u_csbu_monitor (.ref_clk, .rst, .ce, .issueValid, .issueReady,
    .opSel, .operandA, .bitSel, .nextTwoWord, .statusIn, .ioData, .ioRead, .flagsWe, .pcLoad, .done);

// ==== dv/csbu_compare_skip_branch_unit_bench.sv ====
`timescale 1ns/1ps
`include "csbu_regs.vh"
module csbu_compare_skip_branch_unit_bench;
    logic ref_clk = 0, rst = 1, ce = 1, issueValid = 0, nextTwoWord = 0;
    logic [3:0] opSel = 0;
    logic [7:0] operandA = 0, operandB = 0, statusIn = 0, ioData = 0;
    logic [2:0] bitSel = 0;
    logic [6:0] branchOffset = 0;
    logic [15:0] pcIn = 16'h0100;
    logic issueReady, flagsWe, pcLoad, done;
    logic [7:0] flagsOut;
    logic [15:0] pcOut;
    logic [5:0] ioAddr;
    int miscompares = 0, check_count = 0, ticks = 0;
    csbu_compare_skip_branch_unit u_csbu_compare_skip_branch_unit (.ref_clk, .rst, .ce, .issueValid, .issueReady,
        .opSel, .operandA, .operandB, .bitSel, .branchOffset, .pcIn, .nextTwoWord, .statusIn, .ioAddrIn(6'h1F),
        .ioAddr(ioAddr), .ioRead(), .ioData, .flagsOut, .flagsWe, .pcOut, .pcLoad, .done);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        ticks++;
        if (ticks == 3000) begin
            miscompares++;
            stop_test;
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] cmpf(input logic [7:0] a, b, st, input logic cin, zk);
        logic [7:0] r, bo;
        r = a - b - cin;
        bo = (~a & b) | (b & r) | (r & ~a);
        return {st[7:6], bo[3], st[4], (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]), r[7], (r == 0) & zk, bo[7]};
    endfunction
    // Issue one operation, then count cycles up to done and note any flag write or PC load
    task automatic run(input logic [3:0] op, input logic [7:0] a, b, st, input logic [2:0] s,
                       input logic [6:0] k, input logic two, input int cyc, input logic [15:0] pc);
        int n = 0;
        logic fw = 0;
        logic [15:0] pm = 16'h0000;
        @(posedge ref_clk);
        {opSel, operandA, ioData, operandB, statusIn, bitSel} <= {op, a, a, b, st, s};
        {branchOffset, nextTwoWord, issueValid} <= {k, two, 1'b1};
        @(posedge ref_clk);
        issueValid <= 1'b0;
        do begin
            #1;
            n++;
            fw |= flagsWe === 1'b1;
            if (pcLoad === 1'b1) pm = pcOut;
            if (done !== 1'b1) @(posedge ref_clk);
        end while (done !== 1'b1 && n < 8);
        chk({fw, n[3:0], pm}, {op[3:1] == 3'h0, cyc[3:0], pc});
    endtask
    task automatic cmp(input logic [3:0] op, input logic [7:0] a, b, st);
        logic cy = op == `CSBU_OP_CMP_CARRY;
        run(op, a, b, st, 3'h0, 7'h00, 1'b0, 1, 16'h0000);
        chk(flagsOut, cmpf(a, b, st, cy & st[0], cy ? st[1] : 1'b1));
    endtask
    task automatic t_cmp;
        cmp(`CSBU_OP_CMP_CARRY, 8'h10, 8'h10, 8'h43);
        cmp(`CSBU_OP_CMP_CARRY, 8'h05, 8'h05, 8'h02);
        cmp(`CSBU_OP_CMP_CARRY, 8'h05, 8'h05, 8'h00);
        cmp(`CSBU_OP_CMP_IMM, 8'h80, 8'h01, 8'h40);
        cmp(`CSBU_OP_CMP_IMM, 8'h3C, 8'h3C, 8'h01);
    endtask
    task automatic t_skip;
        logic [7:0] m;
        logic sk;
        for (int op = 2; op < 6; op++) for (int v = 0; v < 4; v++) begin
            m = op[1] ? 8'h01 : 8'h80;
            sk = v[0] == op[0];
            run(op, v[0] ? m : ~m, 8'h00, 8'hFF, op[1] ? 3'h0 : 3'h7, 7'h00, v[1], sk ? 2 + v[1] : 1,
                sk ? 16'h0102 + v[1] : 16'h0000);
        end
    endtask
    task automatic t_branch;
        logic [7:0] st;
        logic [6:0] k;
        logic tk;
        int ix;
        for (int op = 6; op < 16; op++) for (int v = 0; v < 3; v++) begin
            st = v == 2 ? 8'h22 : {8{v[0]}};
            k = v[0] ? 7'h40 : 7'h3F;
            ix = op < 8 ? 5 : op < 10 ? 1 : op < 14 ? 0 : 2;
            // Same-or-higher and lower share carry with the opposite sense to the carry pair
            tk = st[ix] == (op[0] ^ (op[3:1] != 3'h6));
            run(op, 8'h00, 8'h00, st, 3'h5, k, 1'b0, tk ? 2 : 1,
                tk ? 16'h0101 + {{9{k[6]}}, k} : 16'h0000);
        end
    endtask
    // A frozen enable must neither take an issue nor advance a taken branch
    task automatic t_ce;
        @(posedge ref_clk);
        {opSel, statusIn, branchOffset, issueValid, ce} <= {`CSBU_OP_BR_EQUAL, 8'h02, 7'h01, 1'b1, 1'b0};
        repeat (2) @(posedge ref_clk);
        #1;
        chk({pcLoad, done, issueReady}, 3'h1);
        @(posedge ref_clk);
        ce <= 1'b1;
        @(posedge ref_clk);
        issueValid <= 1'b0;
        ce <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({pcLoad, done, pcOut}, {2'h2, 16'h0102});
        @(posedge ref_clk);
        ce <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({pcLoad, done}, 2'h1);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk({flagsWe, pcLoad, done, issueReady, flagsOut, pcOut}, {4'h1, 24'h000000});
        chk(ioAddr, 6'h1F);
        t_cmp;
        t_skip;
        t_branch;
        t_ce;
        stop_test;
    end
endmodule
